/* rtl/btp_consts.svh */
// register map, field positions, reset values and function code of the pwm timer
`ifndef BTP_CONSTS_SVH
`define BTP_CONSTS_SVH
// ************************************
// register byte offsets
// ************************************
`define BTP_OFS_CTRL     8'h00
`define BTP_OFS_STAT     8'h04
`define BTP_OFS_PERIOD   8'h08
`define BTP_OFS_DUTY     8'h0c
`define BTP_OFS_COUNT    8'h10
// ************************************
// main control fields
// ************************************
`define BTP_B_SWTRIG     0
`define BTP_B_COUNT_ENABLE_BIT       1
`define BTP_B_ONESHOT    2
`define BTP_B_OUTPUT_POLARITY       3
`define BTP_F_FUNC_HI    6
`define BTP_F_FUNC_LO    4
`define BTP_F_EDGE_HI    9
`define BTP_F_EDGE_LO    8
`define BTP_B_MASK       10
`define BTP_B_RESTART    11
`define BTP_F_CKS_HI     14
`define BTP_F_CKS_LO     12
`define BTP_CTRL_WMASK   16'h7f7e
`define BTP_FUNC_PWM     3'h1
// ************************************
// status and enable fields
// ************************************
`define BTP_B_CLOCK_SELECT_MSB       8
`define BTP_F_IEN_HI     6
`define BTP_F_IEN_LO     4
`define BTP_F_FLAG_HI    2
`define BTP_F_FLAG_LO    0
`define BTP_FLAG_UF      0
`define BTP_FLAG_DUTY    1
`define BTP_FLAG_TRIG    2
// ************************************
// reset values and counter maximum
// ************************************
`define BTP_RST_CTRL     16'h0000
`define BTP_RST_PERIOD   16'h0000
`define BTP_RST_DUTY     16'hffff
`define BTP_RST_COUNT    16'h0000
`define BTP_CNT_MAX      16'hffff
`endif

/* rtl/btp_pkg.sv */
// types shared by the pwm timer modules
package btp_pkg;
   typedef enum logic {BTP_IDLE, BTP_RUN} btp_state_t;
   typedef logic [15:0] btp_half_t;
   typedef logic [3:0]  btp_cks_t;
endpackage

/* rtl/btp_prescale.sv */
// count clock prescaler: turns the clock select code into a count enable
`timescale 1ns/1ps
module btp_prescale
   import btp_pkg::*;
(
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire btp_pkg::btp_cks_t cks_in,
   input  wire logic          ext_rise_in,
   input  wire logic          ext_fall_in,
   output logic               tick_out
);
   import btp_pkg::*;

   typedef struct packed {
      logic [10:0] div;
   } btp_pre_t;

   btp_pre_t r_q;
   btp_pre_t r_d;

   // true once every 2**n clocks
   function automatic logic hit(input logic [10:0] d, input int n);
      logic [10:0] m;
      m = 11'((1 << n) - 1);
      return (d & m) == m;
   endfunction

   always_comb begin
      r_d     = r_q;
      r_d.div = 11'(r_q.div + 11'h1);
      case (cks_in)
         4'h0:    tick_out = 1'b1;
         4'h1:    tick_out = hit(r_q.div, 2);
         4'h2:    tick_out = hit(r_q.div, 4);
         4'h3:    tick_out = hit(r_q.div, 7);
         4'h4:    tick_out = hit(r_q.div, 8);
         4'h5:    tick_out = ext_rise_in;
         4'h6:    tick_out = ext_fall_in;
         4'h7:    tick_out = ext_rise_in | ext_fall_in;
         4'h8:    tick_out = hit(r_q.div, 9);
         4'h9:    tick_out = hit(r_q.div, 10);
         4'ha:    tick_out = hit(r_q.div, 11);
         // prohibited codes freeze the counter
         default: tick_out = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
endmodule // btp_prescale

/* rtl/btp_top.sv */
// 16-bit down-counting pwm timer channel with apb register access
// Notes on behaviour
// - oneshot_select 0 gives continuous pulses, 1 gives a single pulse.
// - count_enable_bit 1 runs the down counter; writing 0 stops it.
// - writing count_enable_bit 1 drives the waveform low, unless a duty match falls in the same cycle.
// - software_trigger starts the timer while enabled; it always reads 0.
// - writing enable and trigger together also triggers.
// - software trigger works whatever the trigger edge select holds.
// - clock_select_msb sits at bit 8; bits 15 to 9 read 0.
// - each flag with its enable set raises the cpu interrupt request.
// - trigger_flag sets on software trigger or valid external edge.
// - duty_match_flag sets when counter equals the duty setting.
// - underflow_flag sets when counter steps on from 0x0000, to the period, or to 0xffff in one-shot.
// - writing 0 clears a flag; writing 1 leaves it unchanged.
// - read-modify-write reads return 1 for every flag.
// - period buffer loads the counter at start and each underflow in continuous mode.
// - duty buffer takes effect at underflow and resets to all ones.
// - equal period and duty give all high, or all low when inverted.
// - counter_value is read only, shows the live counter, resets to zero.
// - pwm behaviour only while function_select holds the pwm code.
// - output_polarity inverts; the output mask then holds the pin high.
`timescale 1ns/1ps
`include "btp_consts.svh"
module btp_top
   import btp_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic        rmw_read_in,
   input  wire logic        ext_clk_in,
   input  wire logic        trig_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             pwm_out,
   output logic             irq_out
);
   import btp_pkg::*;

   // ************************************
   // state
   // ************************************
   typedef struct packed {
      btp_state_t  st;
      btp_half_t   ctrl;
      logic        clock_select_msb;
      logic [2:0]  ien;
      logic [2:0]  flag;
      btp_half_t   period;
      btp_half_t   duty_buf;
      btp_half_t   duty_act;
      btp_half_t   cnt;
      logic        level;
      logic        pwm;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [1:0]  ext_s;
      logic        ext_p;
      logic [1:0]  trg_s;
      logic        trg_p;
   } btp_reg_t;

   btp_reg_t r_q;
   btp_reg_t r_d;
   logic     tick;
   logic     ext_rise;
   logic     ext_fall;
   logic     trg_rise;
   logic     trg_fall;
   logic     setup;
   logic     wr;
   logic     pwm_sel;
   logic     sw_trig;
   logic     ext_trig;
   logic     start;
   logic     uf;
   logic     chk;

   // ************************************
   // edge detect behind the synchronisers
   // ************************************
   assign ext_rise = r_q.ext_s[1] & ~r_q.ext_p;
   assign ext_fall = ~r_q.ext_s[1] & r_q.ext_p;
   assign trg_rise = r_q.trg_s[1] & ~r_q.trg_p;
   assign trg_fall = ~r_q.trg_s[1] & r_q.trg_p;

   btp_prescale u_pre (
      .clk_sys_in  (clk_sys_in),
      .rst_n_in    (rst_n_in),
      .cks_in      ({r_q.clock_select_msb, r_q.ctrl[`BTP_F_CKS_HI:`BTP_F_CKS_LO]}),
      .ext_rise_in (ext_rise),
      .ext_fall_in (ext_fall),
      .tick_out    (tick)
   );

   // ************************************
   // next state
   // ************************************
   always_comb begin
      r_d         = r_q;
      r_d.pready  = 1'b0;
      r_d.pslverr = 1'b0;
      r_d.prdata  = '0;
      r_d.ext_s   = {r_q.ext_s[0], ext_clk_in};
      r_d.ext_p   = r_q.ext_s[1];
      r_d.trg_s   = {r_q.trg_s[0], trig_in};
      r_d.trg_p   = r_q.trg_s[1];
      setup   = psel_in & ~penable_in;
      wr      = psel_in & penable_in & r_q.pready & pwrite_in;
      // enable and trigger in one write also counts as a trigger
      sw_trig = wr && paddr_in == `BTP_OFS_CTRL && pwdata_in[`BTP_B_SWTRIG]
                && pwdata_in[`BTP_B_COUNT_ENABLE_BIT];
      case (r_q.ctrl[`BTP_F_EDGE_HI:`BTP_F_EDGE_LO])
         2'h1:    ext_trig = trg_rise;
         2'h2:    ext_trig = trg_fall;
         2'h3:    ext_trig = trg_rise | trg_fall;
         default: ext_trig = 1'b0;
      endcase
      ext_trig = ext_trig & r_q.ctrl[`BTP_B_COUNT_ENABLE_BIT];
      start = 1'b0;
      uf    = 1'b0;
      chk   = 1'b0;

      // register writes
      if (wr) begin
         case (paddr_in)
            `BTP_OFS_CTRL: begin
               r_d.ctrl = pwdata_in[15:0] & `BTP_CTRL_WMASK;
               if (pwdata_in[`BTP_B_COUNT_ENABLE_BIT]) begin
                  r_d.level = 1'b0;
               end else begin
                  r_d.st = BTP_IDLE;
               end
            end
            `BTP_OFS_STAT: begin
               r_d.clock_select_msb = pwdata_in[`BTP_B_CLOCK_SELECT_MSB];
               r_d.ien  = pwdata_in[`BTP_F_IEN_HI:`BTP_F_IEN_LO];
               r_d.flag = r_q.flag & pwdata_in[`BTP_F_FLAG_HI:`BTP_F_FLAG_LO];
            end
            `BTP_OFS_PERIOD: r_d.period   = pwdata_in[15:0];
            `BTP_OFS_DUTY:   r_d.duty_buf = pwdata_in[15:0];
            default: ;
         endcase
      end

      // follows the control word just written, else enable plus trigger would be lost
      pwm_sel = r_d.ctrl[`BTP_F_FUNC_HI:`BTP_F_FUNC_LO] == `BTP_FUNC_PWM;
      if (pwm_sel && r_d.ctrl[`BTP_B_COUNT_ENABLE_BIT]) begin
         if (sw_trig || ext_trig) begin
            r_d.flag[`BTP_FLAG_TRIG] = 1'b1;
            // a running timer only restarts when restart is enabled
            start = r_q.st == BTP_IDLE || r_q.ctrl[`BTP_B_RESTART];
         end
         case (r_q.st)
            BTP_IDLE: ;
            BTP_RUN: begin
               if (tick && !start) begin
                  if (r_q.cnt == '0) begin
                     uf                     = 1'b1;
                     r_d.flag[`BTP_FLAG_UF] = 1'b1;
                     r_d.duty_act           = r_q.duty_buf;
                     r_d.level              = 1'b0;
                     if (r_q.ctrl[`BTP_B_ONESHOT]) begin
                        r_d.cnt = `BTP_CNT_MAX;
                        r_d.st  = BTP_IDLE;
                     end else begin
                        r_d.cnt = r_q.period;
                        chk     = 1'b1;
                     end
                  end else begin
                     r_d.cnt = 16'(r_q.cnt - 16'h1);
                     chk     = 1'b1;
                  end
               end
            end
            default: r_d.st = BTP_IDLE;
         endcase
         if (start) begin
            r_d.cnt      = r_q.period;
            r_d.duty_act = r_q.duty_buf;
            r_d.level    = 1'b0;
            r_d.st       = BTP_RUN;
            chk          = 1'b1;
         end
         // a match right at reload keeps the pin high all period
         if (chk && r_d.cnt == r_d.duty_act) begin
            r_d.flag[`BTP_FLAG_DUTY] = 1'b1;
            r_d.level                = 1'b1;
         end
      end else if (!pwm_sel) begin
         r_d.st = BTP_IDLE;
      end

      // mask and polarity act at once, from the stored control
      r_d.pwm = (r_d.level & ~r_q.ctrl[`BTP_B_MASK]) ^ r_q.ctrl[`BTP_B_OUTPUT_POLARITY];
      r_d.irq = |(r_d.flag & r_d.ien);

      // read data is prepared in the setup cycle, no wait states
      if (setup) begin
         r_d.pready = 1'b1;
         case (paddr_in)
            `BTP_OFS_CTRL:   r_d.prdata = {16'h0, r_q.ctrl};
            `BTP_OFS_STAT:   r_d.prdata = {23'h0, r_q.clock_select_msb, 1'b0, r_q.ien, 1'b0,
                                           r_q.flag | {3{rmw_read_in}}};
            `BTP_OFS_PERIOD: r_d.prdata = {16'h0, r_q.period};
            `BTP_OFS_DUTY:   r_d.prdata = {16'h0, r_q.duty_buf};
            `BTP_OFS_COUNT:  r_d.prdata = {16'h0, r_q.cnt};
            default:         r_d.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         r_q          <= '0;
         r_q.st       <= BTP_IDLE;
         r_q.ctrl     <= `BTP_RST_CTRL;
         r_q.period   <= `BTP_RST_PERIOD;
         r_q.duty_buf <= `BTP_RST_DUTY;
         r_q.duty_act <= `BTP_RST_DUTY;
         r_q.cnt      <= `BTP_RST_COUNT;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata_out  = r_q.prdata;
   assign pready_out  = r_q.pready;
   assign pslverr_out = r_q.pslverr;
   assign pwm_out     = r_q.pwm;
   assign irq_out     = r_q.irq;

   // ************************************
   // assertions
   // ************************************
   property p_trig_reads_zero;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (setup && !pwrite_in && paddr_in == `BTP_OFS_CTRL) |=> (prdata_out[0] == 1'b0 && pready_out);
   endproperty
   a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger bit read as 1");

   property p_uf_flag;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      uf |=> r_q.flag[`BTP_FLAG_UF] && r_q.cnt == (r_q.ctrl[`BTP_B_ONESHOT] ? 16'hffff : $past(r_q.period));
   endproperty
   a_uf_flag: assert property (p_uf_flag) else $error("underflow did not set flag or reload");

   property p_duty_flag;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (chk && r_d.cnt == r_d.duty_act) |=> r_q.flag[`BTP_FLAG_DUTY] && r_q.level;
   endproperty
   a_duty_flag: assert property (p_duty_flag) else $error("duty match lost");

   property p_clear;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr && paddr_in == `BTP_OFS_STAT && !pwdata_in[0] && !uf) |=> !r_q.flag[`BTP_FLAG_UF];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared by 0");

   property p_set_wins;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (uf && wr && paddr_in == `BTP_OFS_STAT) |=> r_q.flag[`BTP_FLAG_UF];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost against clear");

   property p_irq;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      ##1 (irq_out == |($past(r_d.flag) & $past(r_d.ien)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request mismatch");

   property p_enable_low;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr && paddr_in == `BTP_OFS_CTRL && pwdata_in[1:0] == 2'h2 && !r_q.ctrl[`BTP_B_MASK]
       && !r_q.ctrl[`BTP_B_OUTPUT_POLARITY]) |=> !pwm_out;
   endproperty
   a_enable_low: assert property (p_enable_low) else $error("enable did not drive low");

   property p_start_load;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      start |=> (r_q.cnt == $past(r_q.period)) && r_q.st == BTP_RUN && r_q.flag[`BTP_FLAG_TRIG];
   endproperty
   a_start_load: assert property (p_start_load) else $error("start did not load period");

   property p_mask;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      r_q.ctrl[`BTP_B_MASK] |=> pwm_out == $past(r_q.ctrl[`BTP_B_OUTPUT_POLARITY]);
   endproperty
   a_mask: assert property (p_mask) else $error("mask level wrong");

   property p_stat_reserved;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (setup && paddr_in == `BTP_OFS_STAT) |=> prdata_out[31:9] == '0 && !prdata_out[7] && !prdata_out[3];
   endproperty
   a_stat_reserved: assert property (p_stat_reserved) else $error("reserved status bits set");

   c_underflow: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) uf);
   c_oneshot:   cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
                                uf && r_q.ctrl[`BTP_B_ONESHOT]);
   c_ext_trig:  cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) ext_trig && start);
   c_irq:       cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) irq_out);
endmodule // btp_top

/* sim/tb_base_timer_pwm_mode.sv */
// self-checking testbench of the pwm timer channel over apb
`timescale 1ns/1ps
`include "btp_consts.svh"
module tb_base_timer_pwm_mode;
   import btp_pkg::*;
   // ************************************
   // signals
   // ************************************
   logic        clk_sys_in;
   logic        rst_n_in;
   logic        psel_in;
   logic        penable_in;
   logic        pwrite_in;
   logic [7:0]  paddr_in;
   logic [31:0] pwdata_in;
   logic        rmw_read_in;
   logic        ext_clk_in;
   logic        trig_in;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        pwm_out;
   logic        irq_out;
   int          bad_count;
   int          checked;
   logic [31:0] rd;
   logic [31:0] c1;
   logic        err;
   int          hi;

   btp_top dut (
      .clk_sys_in  (clk_sys_in),
      .rst_n_in    (rst_n_in),
      .psel_in     (psel_in),
      .penable_in  (penable_in),
      .pwrite_in   (pwrite_in),
      .paddr_in    (paddr_in),
      .pwdata_in   (pwdata_in),
      .rmw_read_in (rmw_read_in),
      .ext_clk_in  (ext_clk_in),
      .trig_in     (trig_in),
      .prdata_out  (prdata_out),
      .pready_out  (pready_out),
      .pslverr_out (pslverr_out),
      .pwm_out     (pwm_out),
      .irq_out     (irq_out)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   // ************************************
   // tasks
   // ************************************
   task automatic end_sim();
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: bit got %b exp %b", $time, got, exp);
      end
   endtask

   // waits for pready under a bound; master holds everything until then
   task automatic xfer(input logic wr, input logic rmw, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel_in     <= 1'b1;
      penable_in  <= 1'b0;
      pwrite_in   <= wr;
      paddr_in    <= a;
      pwdata_in   <= wd;
      rmw_read_in <= rmw;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("wrong value at %0t: no ready", $time);
         end_sim();
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in     <= 1'b0;
      penable_in  <= 1'b0;
      rmw_read_in <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, 1'b0, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, 1'b0, a, 32'h0000_0000);
      chk32(rd, exp);
   endtask

   // counts high cycles of the pin after a settling gap
   task automatic high_cnt(input logic [31:0] exp);
      hi = 0;
      repeat (8) @(posedge clk_sys_in);
      repeat (40) begin
         @(posedge clk_sys_in);
         if (pwm_out === 1'b1) hi++;
      end
      chk32(32'(hi), exp);
   endtask

   // ************************************
   // main sequence
   // ************************************
   initial begin
      bad_count = 0;
      checked = 0;
      rst_n_in = 1'b0;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0000_0000;
      rmw_read_in = 1'b0;
      ext_clk_in = 1'b0;
      trig_in = 1'b0;
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      rd_chk(`BTP_OFS_CTRL, 32'h0000_0000);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0000);
      rd_chk(`BTP_OFS_PERIOD, 32'h0000_0000);
      rd_chk(`BTP_OFS_DUTY, 32'h0000_ffff);
      rd_chk(`BTP_OFS_COUNT, 32'h0000_0000);
      chk1(pwm_out, 1'b0);
      chk1(irq_out, 1'b0);
      // unmapped place refuses with an error and reads zero
      xfer(1'b0, 1'b0, 8'h14, 32'h0000_0000);
      chk1(err, 1'b1);
      chk32(rd, 32'h0000_0000);
      // reserved bits read 0, flags cannot be set by software
      wr(`BTP_OFS_STAT, 32'hffff_ffff);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0170);
      wr(`BTP_OFS_STAT, 32'h0000_0000);
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_PERIOD, 32'h0000_0003);
      wr(`BTP_OFS_DUTY, 32'h0000_0001);
      wr(`BTP_OFS_COUNT, 32'h0000_1234);
      rd_chk(`BTP_OFS_COUNT, 32'h0000_0000);
      wr(`BTP_OFS_CTRL, 32'h0000_0013);
      #1 chk1(pwm_out, 1'b0);
      rd_chk(`BTP_OFS_CTRL, 32'h0000_0012);
      high_cnt(32'd20);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0007);
      chk1(irq_out, 1'b0);
      wr(`BTP_OFS_STAT, 32'h0000_0010);
      repeat (8) @(posedge clk_sys_in);
      chk1(irq_out, 1'b1);
      // stop keeps the counter frozen
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      xfer(1'b0, 1'b0, `BTP_OFS_COUNT, 32'h0000_0000);
      c1 = rd;
      repeat (5) @(posedge clk_sys_in);
      rd_chk(`BTP_OFS_COUNT, c1);
      wr(`BTP_OFS_STAT, 32'h0000_0000);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0000);
      chk1(irq_out, 1'b0);
      xfer(1'b0, 1'b1, `BTP_OFS_STAT, 32'h0000_0000);
      chk32(rd, 32'h0000_0007);
      // without the pwm function code a trigger does nothing
      wr(`BTP_OFS_CTRL, 32'h0000_0003);
      repeat (5) @(posedge clk_sys_in);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0000);
      rd_chk(`BTP_OFS_COUNT, c1);
      // equal period and duty, polarity and mask
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_DUTY, 32'h0000_0003);
      wr(`BTP_OFS_CTRL, 32'h0000_0013);
      high_cnt(32'd40);
      wr(`BTP_OFS_CTRL, 32'h0000_0012);
      #1 chk1(pwm_out, 1'b0);
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_CTRL, 32'h0000_001b);
      high_cnt(32'd0);
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_CTRL, 32'h0000_041b);
      high_cnt(32'd40);
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_CTRL, 32'h0000_0413);
      high_cnt(32'd0);
      // one-shot: a single period, then the counter rests
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_DUTY, 32'h0000_0001);
      wr(`BTP_OFS_STAT, 32'h0000_0000);
      wr(`BTP_OFS_CTRL, 32'h0000_0017);
      repeat (20) @(posedge clk_sys_in);
      rd_chk(`BTP_OFS_COUNT, 32'h0000_ffff);
      chk1(pwm_out, 1'b0);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0007);
      // external rising edge starts the timer and raises the trigger flag
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_STAT, 32'h0000_0040);
      wr(`BTP_OFS_CTRL, 32'h0000_0112);
      repeat (6) @(posedge clk_sys_in);
      rd_chk(`BTP_OFS_STAT, 32'h0000_0040);
      chk1(irq_out, 1'b0);
      trig_in <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
      xfer(1'b0, 1'b0, `BTP_OFS_STAT, 32'h0000_0000);
      chk32(rd & 32'h0000_0004, 32'h0000_0004);
      chk1(irq_out, 1'b1);
      // divided count clock: period 4, one step every 4 clocks
      wr(`BTP_OFS_CTRL, 32'h0000_0010);
      wr(`BTP_OFS_PERIOD, 32'h0000_0004);
      wr(`BTP_OFS_DUTY, 32'h0000_0001);
      wr(`BTP_OFS_CTRL, 32'h0000_1013);
      high_cnt(32'd16);
      end_sim();
   end
endmodule // tb_base_timer_pwm_mode
